// >>> shared/epc_pkg.sv
// Operation
// - deferred service set bit reads pending, sets
// - only a register write pends deferred service
// - write one to bit 27 clears deferred service
// - clear bits 27, 25 are write-only
// - tick timer set bit 26 reads, sets pending
// - write one to bit 25 clears tick timer
// - bit 23 shows halt release takes interrupt
// - bit 23 reads zero outside debug mode
// - bit 22 shows any peripheral interrupt pending
// - reserved bits 24, 21:18 read zero
// - privileged aligned word accesses only
package epc_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] EPC_OFF_CTL = 12'hD04;
  localparam logic [11:0] EPC_OFF_STAT = 12'hD40;
  localparam logic [11:0] EPC_OFF_EN = 12'hD44;
  localparam logic [11:0] EPC_OFF_CLR = 12'hD48;
  localparam logic [31:0] EPC_RST_WORD = 32'h0000_0000;

  // ==========================================================
  // control word fields
  localparam int EPC_BIT_DS_SET = 28;
  localparam int EPC_BIT_DS_CLR = 27;
  localparam int EPC_BIT_TT_SET = 26;
  localparam int EPC_BIT_TT_CLR = 25;
  localparam int EPC_BIT_RSV = 24;
  localparam int EPC_BIT_HALT = 23;
  localparam int EPC_BIT_ANY = 22;
  localparam int EPC_RSV_HI = 21;
  localparam int EPC_RSV_LO = 18;

  // ==========================================================
  // event status layout
  localparam int EPC_EV_W = 3;
  localparam int EPC_EV_DS = 0;
  localparam int EPC_EV_TT = 1;
  localparam int EPC_EV_BAD = 2;
  localparam logic [EPC_EV_W-1:0] EPC_EV_RST = 3'h0;

  // ==========================================================
  // bus answers
  localparam logic [1:0] EPC_OKAY = 2'h0;
  localparam logic [1:0] EPC_SLVERR = 2'h2;
  localparam logic [1:0] EPC_DECERR = 2'h3;
  localparam logic [3:0] EPC_FULL_STRB = 4'hF;

  function automatic logic epc_hit(input logic [11:0] addr);
    logic [9:0] w;
    w = addr[11:2];
    return (w == EPC_OFF_CTL[11:2]) || (w == EPC_OFF_STAT[11:2]) ||
      (w == EPC_OFF_EN[11:2]) || (w == EPC_OFF_CLR[11:2]);
  endfunction

  function automatic logic [1:0] epc_resp(input logic [11:0] addr, input logic priv,
    input logic [3:0] strb);
    logic [1:0] r;
    r = EPC_OKAY;
    if (!epc_hit(addr))
      r = EPC_DECERR;
    else if ((addr[1:0] != 2'h0) || !priv || (strb != EPC_FULL_STRB))
      r = EPC_SLVERR;
    return r;
  endfunction

endpackage

// >>> src/epc_pend_bit.sv
`timescale 1ns/1ps
module epc_pend_bit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic pend
);

  typedef struct packed {
    logic pend;
  } epc_pend_s;

  epc_pend_s s_reg;
  epc_pend_s s_next;

  // set wins so a set landing with a clear is not lost
  always_comb
  begin
    s_next = s_reg;
    s_next.pend = set | (s_reg.pend & ~clr);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign pend = s_reg.pend;

endmodule

// >>> src/epc_irq_ctl.sv
`timescale 1ns/1ps
module epc_irq_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [epc_pkg::EPC_EV_W-1:0] ev,
  input wire logic en_we,
  input wire logic [epc_pkg::EPC_EV_W-1:0] en_data,
  input wire logic clr_we,
  input wire logic [epc_pkg::EPC_EV_W-1:0] clr_data,
  output logic [epc_pkg::EPC_EV_W-1:0] status,
  output logic [epc_pkg::EPC_EV_W-1:0] enable,
  output logic irq
);

  typedef struct packed {
    logic [epc_pkg::EPC_EV_W-1:0] status;
    logic [epc_pkg::EPC_EV_W-1:0] enable;
    logic irq;
  } epc_irq_s;

  epc_irq_s s_reg;
  epc_irq_s s_next;

  always_comb
  begin
    s_next = s_reg;
    if (clr_we)
      s_next.status = s_reg.status & ~clr_data;
    s_next.status = s_next.status | ev;
    if (en_we)
      s_next.enable = en_data;
    s_next.irq = |(s_next.status & s_next.enable);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg.status <= epc_pkg::EPC_EV_RST;
      s_reg.enable <= epc_pkg::EPC_EV_RST;
      s_reg.irq <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  assign status = s_reg.status;
  assign enable = s_reg.enable;
  assign irq = s_reg.irq;

endmodule

// >>> src/epc_top.sv
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module epc_top #(
  parameter int N_IRQ = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic debug_mode,
  input wire logic halt_release_irq,
  input wire logic [N_IRQ-1:0] periph_irq_pending,
  input wire logic tick_timer_fire,
  input wire logic deferred_service_taken,
  input wire logic tick_timer_taken,
  output logic deferred_service_pending,
  output logic tick_timer_pending,
  output logic irq
);

  // ==========================================================
  // bus state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_hold;
    logic [11:0] aw_addr;
    logic aw_priv;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } epc_bus_s;

  epc_bus_s s_reg;
  epc_bus_s s_next;

  logic wr_go;
  logic wr_ok;
  logic rd_go;
  logic rd_bad;
  logic wr_ctl;
  logic ds_set;
  logic ds_clr;
  logic tt_set;
  logic tt_clr;
  logic ds_pend;
  logic tt_pend;
  logic [31:0] ctl_word;
  logic [epc_pkg::EPC_EV_W-1:0] ev;
  logic [epc_pkg::EPC_EV_W-1:0] ev_status;
  logic [epc_pkg::EPC_EV_W-1:0] ev_enable;
  logic [1:0] rd_resp;
  logic [31:0] rd_word;

  // ==========================================================
  // read view of the control word
  always_comb
  begin
    ctl_word = epc_pkg::EPC_RST_WORD;
    ctl_word[epc_pkg::EPC_BIT_DS_SET] = ds_pend;
    ctl_word[epc_pkg::EPC_BIT_TT_SET] = tt_pend;
    // clear bits and reserved bits stay zero
    ctl_word[epc_pkg::EPC_BIT_DS_CLR] = 1'b0;
    ctl_word[epc_pkg::EPC_BIT_TT_CLR] = 1'b0;
    ctl_word[epc_pkg::EPC_BIT_RSV] = 1'b0;
    ctl_word[epc_pkg::EPC_RSV_HI:epc_pkg::EPC_RSV_LO] = 4'h0;
    ctl_word[epc_pkg::EPC_BIT_HALT] = debug_mode & halt_release_irq;
    ctl_word[epc_pkg::EPC_BIT_ANY] = |periph_irq_pending;
  end

  always_comb
  begin
    rd_word = epc_pkg::EPC_RST_WORD;
    unique case (araddr[11:2])
      epc_pkg::EPC_OFF_CTL[11:2]: rd_word = ctl_word;
      epc_pkg::EPC_OFF_STAT[11:2]: rd_word[epc_pkg::EPC_EV_W-1:0] = ev_status;
      epc_pkg::EPC_OFF_EN[11:2]: rd_word[epc_pkg::EPC_EV_W-1:0] = ev_enable;
      default: rd_word = epc_pkg::EPC_RST_WORD;
    endcase
  end

  // ==========================================================
  // write and read channels
  always_comb
  begin
    s_next = s_reg;
    wr_go = 1'b0;
    wr_ok = 1'b0;
    rd_go = 1'b0;
    rd_resp = epc_pkg::epc_resp(araddr, arprot[0], epc_pkg::EPC_FULL_STRB);
    rd_bad = 1'b0;
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_hold = 1'b1;
      s_next.aw_addr = awaddr;
      s_next.aw_priv = awprot[0];
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_hold = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    // commit once both halves are in, response on the same edge
    if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid)
    begin
      wr_go = 1'b1;
      s_next.aw_hold = 1'b0;
      s_next.w_hold = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = epc_pkg::epc_resp(s_reg.aw_addr, s_reg.aw_priv, s_reg.w_strb);
      wr_ok = (s_next.bresp == epc_pkg::EPC_OKAY);
    end
    // no new write halves while a response is waiting
    s_next.awready = !s_next.aw_hold && !s_next.bvalid;
    s_next.wready = !s_next.w_hold && !s_next.bvalid;
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && s_reg.arready)
    begin
      rd_go = 1'b1;
      rd_bad = (rd_resp != epc_pkg::EPC_OKAY);
      s_next.rvalid = 1'b1;
      s_next.rresp = rd_resp;
      s_next.rdata = rd_bad ? epc_pkg::EPC_RST_WORD : rd_word;
    end
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // pending state
  assign wr_ctl = wr_ok && (s_reg.aw_addr[11:2] == epc_pkg::EPC_OFF_CTL[11:2]);
  // only the register write can pend the deferred service
  assign ds_set = wr_ctl && s_reg.w_data[epc_pkg::EPC_BIT_DS_SET];
  assign ds_clr = (wr_ctl && s_reg.w_data[epc_pkg::EPC_BIT_DS_CLR]) ||
    deferred_service_taken;
  assign tt_set = (wr_ctl && s_reg.w_data[epc_pkg::EPC_BIT_TT_SET]) ||
    tick_timer_fire;
  assign tt_clr = (wr_ctl && s_reg.w_data[epc_pkg::EPC_BIT_TT_CLR]) ||
    tick_timer_taken;

  // updates land on the response edge, so a later read sees them
  epc_pend_bit u_ds (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(ds_set),
    .clr(ds_clr),
    .pend(ds_pend)
  );

  epc_pend_bit u_tt (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(tt_set),
    .clr(tt_clr),
    .pend(tt_pend)
  );

  // ==========================================================
  // event interrupt
  always_comb
  begin
    ev = '0;
    ev[epc_pkg::EPC_EV_DS] = ds_set;
    ev[epc_pkg::EPC_EV_TT] = tt_set;
    ev[epc_pkg::EPC_EV_BAD] = (wr_go && !wr_ok) || rd_bad;
  end

  epc_irq_ctl u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev),
    .en_we(wr_ok && (s_reg.aw_addr[11:2] == epc_pkg::EPC_OFF_EN[11:2])),
    .en_data(s_reg.w_data[epc_pkg::EPC_EV_W-1:0]),
    .clr_we(wr_ok && (s_reg.aw_addr[11:2] == epc_pkg::EPC_OFF_CLR[11:2])),
    .clr_data(s_reg.w_data[epc_pkg::EPC_EV_W-1:0]),
    .status(ev_status),
    .enable(ev_enable),
    .irq(irq)
  );

  // ==========================================================
  // outputs
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign deferred_service_pending = ds_pend;
  assign tick_timer_pending = tt_pend;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_DS_SET: assert property (
    ds_set |=> deferred_service_pending)
    else $error("deferred service set did not pend");

  AST_DS_ONLY_SW: assert property (
    $rose(deferred_service_pending) |-> $past(wr_ctl) &&
      $past(s_reg.w_data[epc_pkg::EPC_BIT_DS_SET]))
    else $error("deferred service pended without a write");

  AST_DS_CLR: assert property (
    (wr_ctl && s_reg.w_data[epc_pkg::EPC_BIT_DS_CLR] &&
      !s_reg.w_data[epc_pkg::EPC_BIT_DS_SET]) |=> !deferred_service_pending)
    else $error("deferred service clear ignored");

  AST_WO_ZERO: assert property (
    rvalid |-> (rdata[epc_pkg::EPC_BIT_DS_CLR] == 1'b0) &&
      (rdata[epc_pkg::EPC_BIT_TT_CLR] == 1'b0))
    else $error("write-only bit read nonzero");

  AST_TT_SET: assert property (
    tt_set |=> tick_timer_pending)
    else $error("tick timer set did not pend");

  AST_TT_CLR: assert property (
    (tt_clr && !tt_set) |=> !tick_timer_pending)
    else $error("tick timer clear ignored");

  AST_HALT_READ: assert property (
    (rd_go && !rd_bad && (araddr[11:2] == epc_pkg::EPC_OFF_CTL[11:2])) |=>
      rdata[epc_pkg::EPC_BIT_HALT] == $past(debug_mode && halt_release_irq))
    else $error("halt release bit wrong");

  AST_HALT_DEBUG: assert property (
    (rd_go && !debug_mode) |=> !rdata[epc_pkg::EPC_BIT_HALT])
    else $error("halt release bit set outside debug");

  AST_ANY_IRQ: assert property (
    (rd_go && !rd_bad && (araddr[11:2] == epc_pkg::EPC_OFF_CTL[11:2])) |=>
      rdata[epc_pkg::EPC_BIT_ANY] == $past(|periph_irq_pending))
    else $error("interrupt pending flag wrong");

  AST_RSV_ZERO: assert property (
    rvalid |-> (rdata[epc_pkg::EPC_BIT_RSV] == 1'b0) &&
      (rdata[epc_pkg::EPC_RSV_HI:epc_pkg::EPC_RSV_LO] == 4'h0))
    else $error("reserved bits read nonzero");

  AST_REFUSE: assert property (
    (wr_go && !wr_ok) |=> (bresp != epc_pkg::EPC_OKAY) && bvalid &&
      $stable(deferred_service_pending))
    else $error("refused write had effect or no error");

  AST_WR_VISIBLE: assert property (
    wr_go |=> bvalid ##0 (deferred_service_pending == $past(ds_set ||
      (ds_pend && !ds_clr))))
    else $error("write not settled at response");

  AST_IRQ: assert property (
    irq |-> |(ev_status & ev_enable))
    else $error("interrupt without enabled status");

  AST_IRQ_LOW: assert property (
    !(|(ev_status & ev_enable)) |-> !irq)
    else $error("interrupt high with nothing enabled");

  AST_B_HOLD: assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before accepted");

  AST_R_HOLD: assert property (
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before accepted");

  AST_W_BLOCK: assert property (
    bvalid |-> !awready && !wready)
    else $error("write half accepted while a response waits");

  AST_R_BLOCK: assert property (
    rvalid |-> !arready)
    else $error("read accepted while data waits");

  AST_RD_REFUSED: assert property (
    (rvalid && (rresp != epc_pkg::EPC_OKAY)) |-> (rdata == epc_pkg::EPC_RST_WORD))
    else $error("refused read returned data");

  AST_TT_HW: assert property (
    tick_timer_fire |=> tick_timer_pending)
    else $error("tick timer event did not pend");

  AST_TT_FALL: assert property (
    $fell(tick_timer_pending) |-> $past(tt_clr) && !$past(tt_set))
    else $error("tick timer pending dropped without a clear");

  AST_DS_FALL: assert property (
    $fell(deferred_service_pending) |-> $past(ds_clr) && !$past(ds_set))
    else $error("deferred service pending dropped without a clear");

  AST_DS_TAKEN: assert property (
    (deferred_service_taken && !ds_set) |=> !deferred_service_pending)
    else $error("handler entry did not clear deferred service");

  COV_DS_CYCLE: cover property (ds_set ##[1:40] ds_clr);
  COV_TT_HW: cover property (tick_timer_fire ##1 tick_timer_pending);
  COV_REFUSED: cover property (wr_go && !wr_ok);
  COV_IRQ: cover property ($rose(irq));
  COV_HALT_READ: cover property (rd_go && debug_mode && halt_release_irq);

endmodule

// >>> bench/epc_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// core side: debug state, peripheral lines, tick timer, handler entry
module epc_core_model #(
  parameter int N_IRQ = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dbg_req,
  input wire logic hri_req,
  input wire logic [N_IRQ-1:0] per_req,
  input wire logic fire_req,
  input wire logic take_en,
  input wire logic deferred_service_pending,
  input wire logic tick_timer_pending,
  output logic debug_mode,
  output logic halt_release_irq,
  output logic [N_IRQ-1:0] periph_irq_pending,
  output logic tick_timer_fire,
  output logic deferred_service_taken,
  output logic tick_timer_taken
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      debug_mode <= 1'b0;
      halt_release_irq <= 1'b0;
      periph_irq_pending <= '0;
      tick_timer_fire <= 1'b0;
      deferred_service_taken <= 1'b0;
      tick_timer_taken <= 1'b0;
    end
    else
    begin
      debug_mode <= dbg_req;
      halt_release_irq <= hri_req;
      periph_irq_pending <= per_req;
      // hardware may pend only the tick timer, never deferred service
      tick_timer_fire <= fire_req;
      // one-cycle entry pulse; pending drops on the edge that ends it, and the pulse repeats while take_en and pending stay high
      deferred_service_taken <= take_en & deferred_service_pending & ~deferred_service_taken;
      tick_timer_taken <= take_en & tick_timer_pending & ~tick_timer_taken;
    end
  end
endmodule

// >>> bench/test_exception_pending_control.sv
`timescale 1ns/1ps
module test_exception_pending_control;
  localparam logic [31:0] DS_SET = 32'h1000_0000;
  localparam logic [31:0] DS_CLR = 32'h0800_0000;
  localparam logic [31:0] TT_SET = 32'h0400_0000;
  localparam logic [31:0] TT_CLR = 32'h0200_0000;
  localparam logic [31:0] HALT = 32'h0080_0000;
  localparam logic [31:0] ANY = 32'h0040_0000;
  localparam logic [11:0] CTL = epc_pkg::EPC_OFF_CTL;
  localparam logic [11:0] STAT = epc_pkg::EPC_OFF_STAT;
  localparam logic [11:0] EN = epc_pkg::EPC_OFF_EN;
  localparam logic [11:0] CLR = epc_pkg::EPC_OFF_CLR;
  localparam logic [1:0] OK = epc_pkg::EPC_OKAY;
  localparam logic [1:0] SLV = epc_pkg::EPC_SLVERR;
  localparam logic [1:0] DEC = epc_pkg::EPC_DECERR;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic debug_mode, halt_release_irq, tick_timer_fire;
  logic deferred_service_taken, tick_timer_taken;
  logic [7:0] periph_irq_pending, per_req;
  logic deferred_service_pending, tick_timer_pending, irq;
  logic dbg_req, hri_req, fire_req, take_en;
  int fail_count, tests_run, i, n;

  epc_top #(.N_IRQ(8)) epc_top_i (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .debug_mode, .halt_release_irq,
    .periph_irq_pending, .tick_timer_fire, .deferred_service_taken, .tick_timer_taken,
    .deferred_service_pending, .tick_timer_pending, .irq);

  epc_core_model #(.N_IRQ(8)) epc_core_model_i (.aclk, .aresetn, .dbg_req, .hri_req,
    .per_req, .fire_req, .take_en, .deferred_service_pending, .tick_timer_pending,
    .debug_mode, .halt_release_irq, .periph_irq_pending, .tick_timer_fire,
    .deferred_service_taken, .tick_timer_taken);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // report
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic hang();
    fail_count++;
    $display("[ERR] %0t bus answer never came", $time);
    results();
  endtask

  task automatic done(input string t);
    $display("test %s done, mismatches so far %0d", t, fail_count);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask

  // ==========================================================
  // bus master; every task starts and ends just after a rising edge
  task automatic wrx(input logic [11:0] a, input logic [31:0] d, input logic [2:0] p,
    input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    awprot <= p;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 50)
      hang();
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
    @(posedge aclk);
  endtask

  // stimulus never sets and clears one exception in the same write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wrx(a, d, 3'h1, 4'hF, OK);
  endtask

  task automatic rdx(input logic [11:0] a, input logic [2:0] p, input logic [31:0] ed,
    input logic [1:0] er);
    araddr <= a;
    arprot <= p;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (n == 50)
      hang();
    chk(rdata, ed, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed);
    rdx(a, 3'h1, ed, OK);
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {dbg_req, hri_req, fire_req, take_en, per_req} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTL, 32'h0);
    rd(STAT, 32'h0);
    chkb(deferred_service_pending | tick_timer_pending | irq, 1'b0, "reset outputs");
    done("reset");
    wr(CTL, DS_SET);
    rd(CTL, DS_SET);
    chkb(deferred_service_pending, 1'b1, "ds pend");
    wr(CTL, 32'h0);
    rd(CTL, DS_SET);
    wr(CTL, DS_CLR);
    rd(CTL, 32'h0);
    chkb(deferred_service_pending, 1'b0, "ds pend");
    done("deferred service");
    wr(CTL, TT_SET);
    rd(CTL, TT_SET);
    chkb(tick_timer_pending, 1'b1, "tt pend");
    wr(CTL, TT_CLR);
    rd(CTL, 32'h0);
    fire_req <= 1'b1;
    idle(1);
    fire_req <= 1'b0;
    idle(4);
    rd(CTL, TT_SET);
    chkb(deferred_service_pending, 1'b0, "ds pend");
    take_en <= 1'b1;
    wr(CTL, DS_SET);
    idle(6);
    rd(CTL, 32'h0);
    take_en <= 1'b0;
    done("tick timer");
    for (i = 0; i < 4; i++)
    begin
      dbg_req <= i[1];
      hri_req <= i[0];
      idle(3);
      rd(CTL, (i == 3) ? HALT : 32'h0);
    end
    dbg_req <= 1'b0;
    done("halt release");
    // halt release stays requested: outside debug it must still read zero
    for (i = 0; i < 8; i++)
    begin
      per_req <= 8'h01 << i;
      idle(3);
      rd(CTL, ANY);
    end
    per_req <= 8'h00;
    idle(3);
    rd(CTL, 32'h0);
    done("peripheral pending");
    wrx(12'h000, DS_SET, 3'h1, 4'hF, DEC);
    wrx(CTL + 12'h1, DS_SET, 3'h1, 4'hF, SLV);
    wrx(CTL, DS_SET, 3'h0, 4'hF, SLV);
    wrx(CTL, DS_SET, 3'h1, 4'h3, SLV);
    rdx(CTL, 3'h0, 32'h0, SLV);
    rdx(CTL + 12'h2, 3'h1, 32'h0, SLV);
    rdx(12'hFFC, 3'h1, 32'h0, DEC);
    rd(CTL, 32'h0);
    done("refused access");
    rd(STAT, 32'h7);
    wr(CLR, 32'h7);
    rd(STAT, 32'h0);
    wr(EN, 32'h1);
    rd(EN, 32'h1);
    chkb(irq, 1'b0, "irq idle");
    wr(CTL, DS_SET);
    rd(STAT, 32'h1);
    chkb(irq, 1'b1, "irq raised");
    wr(EN, 32'h0);
    rd(STAT, 32'h1);
    chkb(irq, 1'b0, "irq masked");
    wr(EN, 32'h1);
    rd(CLR, 32'h0);
    chkb(irq, 1'b1, "irq unmasked");
    wr(CLR, 32'h1);
    rd(STAT, 32'h0);
    chkb(irq, 1'b0, "irq cleared");
    wr(CTL, DS_CLR);
    rd(CTL, 32'h0);
    done("interrupt");
    results();
  end
endmodule
